// File: dv/osc_fb_model.sv
// Model of the frame buffer side: secondary pixel source and background fetch sweep.
`timescale 1ns/1ps
`default_nettype none
module osc_fb_model (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_sweep,
    input wire logic [23:0] i_color,
    input wire logic i_fetch_en,
    output osc_pkg::osc_pix_type o_sec_pix,
    output logic [9:0] o_qword,
    output logic [9:0] o_skipped
);
    // ----------------------------------------
    // Source and sweep
    // ----------------------------------------
    // A flat image keeps every filter and blend result exact, at the cost of tap-order coverage.
    assign o_sec_pix = {1'b1, i_color};
    always_ff @(posedge i_mclk) begin
        o_qword <= (i_rst || !i_sweep) ? 10'h000 : o_qword + 10'h001;
        if (i_rst) begin
            o_skipped <= 10'h000;
        end else if (i_sweep && !i_fetch_en) begin
            o_skipped <= o_skipped + 10'h001;
        end
    end
endmodule
`default_nettype wire

// File: dv/osc_top_properties.sv
// Port checker of the overlay scaler compositor.
`timescale 1ns/1ps
`default_nettype none
module osc_top_properties (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic i_vsync,
    input wire logic i_line_start,
    input wire osc_pkg::osc_pix_type i_sec_pix,
    input wire logic o_sec_ready,
    input wire osc_pkg::osc_pix_type i_pri_pix,
    input wire logic i_in_window,
    input wire logic i_key_match,
    input wire logic [9:0] i_fetch_qword,
    input wire logic o_fetch_en,
    input wire logic o_line_repeat,
    input wire osc_pkg::osc_pix_type o_pix
);
    // ----------------------------------------
    // Shadows and properties
    // ----------------------------------------
    // Only the ports are visible, so the mode and gating fields are rebuilt from the writes.
    logic [2:0] mode_reg;
    logic [31:0] opq_reg;
    logic take;
    logic hidden;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            mode_reg <= 3'h0;
            opq_reg <= 32'h0000_0000;
        end else if (i_wr && i_addr == osc_pkg::ADDR_BLEND) begin
            mode_reg <= i_wdata[26:24];
        end else if (i_wr && i_addr == osc_pkg::ADDR_OPAQUE) begin
            opq_reg <= i_wdata;
        end
    end
    assign take = i_pri_pix.valid && !i_line_start;
    assign hidden = i_fetch_qword >= opq_reg[12:3] && i_fetch_qword <= opq_reg[28:19];
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    AST_RESET_QUIET: assert property ($fell(i_rst) |-> o_fetch_en && !o_pix.valid && o_rdata == 32'h0)
        else $error("outputs busy after reset");
    AST_MODE_READBACK: assert property (i_wr && i_addr == osc_pkg::ADDR_BLEND ##1 !i_wr ##1
        i_rd && i_addr == osc_pkg::ADDR_BLEND |=> o_rdata[26:24] == $past(i_wdata[26:24], 3))
        else $error("mode field read back wrong");
    AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");
    AST_LINE_START_DROP: assert property (i_line_start |=> !o_pix.valid)
        else $error("pixel out at line start");
    AST_PIX_TAKEN: assert property (take |=> o_pix.valid)
        else $error("pixel not produced");
    AST_GATE_OFF: assert property (!opq_reg[31] |-> o_fetch_en)
        else $error("fetch gated while off");
    AST_GATE_HIDDEN: assert property (opq_reg[31] |-> o_fetch_en == !hidden)
        else $error("fetch gating range wrong");
    AST_PRI_SHOWN: assert property (take && (!i_in_window || mode_reg == osc_pkg::MODE_PRI_OPAQUE ||
        mode_reg == osc_pkg::MODE_PRI_KEY && i_key_match) |=> o_pix.data == $past(i_pri_pix.data))
        else $error("primary pixel not shown");
    cover property (take && i_in_window && mode_reg == osc_pkg::MODE_DISSOLVE);
    cover property (!o_fetch_en);
    cover property (i_rd ##1 o_rdata != 32'h0000_0000);
endmodule
bind osc_top osc_top_properties u_osc_top_properties (.*);
`default_nettype wire

// File: dv/test_osc_top.sv
// Self-checking bench of the overlay scaler compositor.
`timescale 1ns/1ps
`default_nettype none
module test_osc_top;
    localparam logic [23:0] PC = 24'h808080;
    localparam logic [23:0] SC = 24'h404040;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic vs = 1'b0;
    logic ls = 1'b0;
    logic inw = 1'b0;
    logic key = 1'b0;
    logic sweep = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata, got;
    logic [9:0] qword, skipped;
    logic fetch_en;
    logic rdy;
    logic rep;
    osc_pkg::osc_pix_type pri = 25'h0000000;
    osc_pkg::osc_pix_type sec, pix;
    logic [2:0] modes [5] = '{3'h1, 3'h5, 3'h5, 3'h6, 3'h6};
    logic keys [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [23:0] exps [5] = '{PC, SC, PC, PC, SC};
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    always #20 mclk = ~mclk;
    osc_top u_osc_top (
        .i_mclk(mclk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_vsync(vs), .i_line_start(ls), .i_sec_pix(sec), .o_sec_ready(rdy),
        .i_pri_pix(pri), .i_in_window(inw), .i_key_match(key), .i_fetch_qword(qword),
        .o_fetch_en(fetch_en), .o_line_repeat(rep), .o_pix(pix)
    );
    osc_fb_model u_osc_fb_model (
        .i_mclk(mclk), .i_rst(rst), .i_sweep(sweep), .i_color(SC), .i_fetch_en(fetch_en),
        .o_sec_pix(sec), .o_qword(qword), .o_skipped(skipped)
    );
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd32(input logic [7:0] a, output logic [31:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge mclk);
    endtask
    // A primary pixel offered with the line start must be dropped, so one rides along.
    task automatic new_line(input logic v);
        vs <= v;
        @(posedge mclk);
        vs <= 1'b0;
        ls <= 1'b1;
        pri <= {1'b1, PC};
        @(posedge mclk);
        ls <= 1'b0;
        pri.valid <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    task automatic pixel(input logic w, input logic k, input logic [23:0] exp);
        pri <= {1'b1, PC};
        inw <= w;
        key <= k;
        @(posedge mclk);
        pri.valid <= 1'b0;
        #1 check({31'h0, pix.valid}, 32'h1);
        check({8'h00, pix.data}, {8'h00, exp});
        @(posedge mclk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            tally_and_finish();
        end
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd32(osc_pkg::ADDR_BLEND, got);
        check(got, 32'h0000_0000);
        rd32(osc_pkg::ADDR_OPAQUE, got);
        check(got, 32'h0000_0000);
        rd32(8'hfc, got);
        check(got, 32'h0000_0000);
        wr32(osc_pkg::ADDR_HSCALE, 32'h0000_0007);
        rd32(osc_pkg::ADDR_HSCALE, got);
        check(got, 32'h0000_0007);
        wr32(osc_pkg::ADDR_VFAC1, 32'h0000_0003);
        wr32(osc_pkg::ADDR_VFAC2, 32'h0000_0000);
        wr32(osc_pkg::ADDR_VACC, 32'h0000_0ffb);
        for (int f = 0; f < 4; f++) begin
            wr32(osc_pkg::ADDR_SEC_CTRL, {1'b0, f[2:0], 28'h0000007});
            new_line(1'b1);
            pixel(1'b1, 1'b0, SC);
        end
        for (int i = 0; i < 5; i++) begin
            wr32(osc_pkg::ADDR_BLEND, {5'h00, modes[i], 24'h000000});
            pixel(1'b1, keys[i], exps[i]);
            pixel(1'b0, keys[i], PC);
        end
        wr32(osc_pkg::ADDR_BLEND, 32'h0200_1000);
        rd32(osc_pkg::ADDR_BLEND, got);
        check(got, 32'h0200_1000);
        pixel(1'b1, 1'b0, SC);
        new_line(1'b1);
        pixel(1'b1, 1'b0, 24'h606060);
        wr32(osc_pkg::ADDR_BLEND, 32'h0300_1008);
        new_line(1'b1);
        pixel(1'b1, 1'b0, 24'h505050);
        rd32(osc_pkg::ADDR_STATUS, got);
        check(got, 32'h0000_3100);
        check({31'h0, rep}, 32'h0000_0001);
        check({31'h0, rdy}, 32'h0000_0001);
        wr32(osc_pkg::ADDR_BLEND, 32'h0000_0000);
        wr32(osc_pkg::ADDR_OPAQUE, 32'h8048_0028);
        sweep <= 1'b1;
        repeat (16) @(posedge mclk);
        sweep <= 1'b0;
        #1 check({22'h0, skipped}, 32'h0000_0005);
        @(posedge mclk);
        wr32(osc_pkg::ADDR_OPAQUE, 32'h0000_0000);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// File: src/osc_csc.sv
// Colour space converter from YCbCr to RGB 8.8.8.
`timescale 1ns/1ps
`default_nettype none
module osc_csc (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_yuv,
    input wire osc_pkg::osc_pix_type i_pix,
    output osc_pkg::osc_pix_type o_pix
);

    typedef struct packed {
        osc_pkg::osc_pix_type pix;
    } osc_csc_state_type;

    osc_csc_state_type state_reg;
    osc_csc_state_type state_next;

    function automatic logic [7:0] clamp(input logic signed [17:0] v);
        if (v < 0) begin
            clamp = 8'h00;
        end else if (v > 18'sd65535) begin
            clamp = 8'hff;
        end else begin
            clamp = v[15:8];
        end
    endfunction

    // Fixed BT.601 coefficients scaled by 256; integer only to keep it one stage.
    always_comb begin
        logic signed [17:0] y;
        logic signed [17:0] cb;
        logic signed [17:0] cr;
        y = 18'sd0;
        cb = 18'sd0;
        cr = 18'sd0;
        state_next = state_reg;
        state_next.pix.valid = i_pix.valid;
        if (i_pix.valid) begin
            if (i_yuv) begin
                y = $signed({10'h000, i_pix.data[23:16]}) <<< 8;
                cb = $signed({10'h000, i_pix.data[15:8]}) - 18'sd128;
                cr = $signed({10'h000, i_pix.data[7:0]}) - 18'sd128;
                state_next.pix.data = {clamp(y + 18'sd359 * cr),
                                       clamp(y - 18'sd88 * cb - 18'sd183 * cr),
                                       clamp(y + 18'sd454 * cb)};
            end else begin
                state_next.pix.data = i_pix.data;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_pix = state_reg.pix;

endmodule
`default_nettype wire

// File: src/osc_pkg.sv
// Package of constants and types for the overlay scaler compositor.
package osc_pkg;

    // ----------------------------------------
    // Register byte addresses (index * 4) as compared with i_addr on the register port
    // ----------------------------------------
    localparam logic [7:0] ADDR_SEC_CTRL = 8'h00;
    localparam logic [7:0] ADDR_HSCALE = 8'h04;
    localparam logic [7:0] ADDR_VFAC1 = 8'h08;
    localparam logic [7:0] ADDR_VFAC2 = 8'h0c;
    localparam logic [7:0] ADDR_VACC = 8'h10;
    localparam logic [7:0] ADDR_BLEND = 8'h14;
    localparam logic [7:0] ADDR_OPAQUE = 8'h18;
    localparam logic [7:0] ADDR_FMT = 8'h1c;
    localparam logic [7:0] ADDR_STATUS = 8'h20;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int FILT_LSB = 28;
    localparam int HACC_LSB = 0;
    localparam int K1_LSB = 0;
    localparam int K2_LSB = 16;
    localparam int MODE_LSB = 24;
    localparam int KP_LSB = 10;
    localparam int KS_LSB = 2;
    localparam int OPQ_EN_BIT = 31;
    localparam int OPQ_TOP_BIT = 30;
    localparam int STOP_LSB = 3;
    localparam int RESTART_LSB = 19;
    localparam int YUV_BIT = 0;

    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

    // ----------------------------------------
    // Encodings
    // ----------------------------------------
    localparam logic [2:0] MODE_SEC_OPAQUE = 3'h0;
    localparam logic [2:0] MODE_PRI_OPAQUE = 3'h1;
    localparam logic [2:0] MODE_DISSOLVE = 3'h2;
    localparam logic [2:0] MODE_FADE = 3'h3;
    localparam logic [2:0] MODE_SEC_KEY = 3'h5;
    localparam logic [2:0] MODE_PRI_KEY = 3'h6;

    localparam logic [2:0] FILT_PASS = 3'h0;
    localparam logic [2:0] FILT_LIN024 = 3'h1;
    localparam logic [2:0] FILT_BILIN = 3'h2;
    localparam logic [2:0] FILT_LIN122 = 3'h3;

    localparam logic [3:0] BLEND_FULL = 4'h8;

    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
    } osc_rgb_type;

    typedef struct packed {
        logic valid;
        logic [23:0] data;
    } osc_pix_type;

endpackage

// File: src/osc_top.sv
// Overlay scaler compositor: scaling DDA, composition, blending and fetch gating.
//
// What this block does
// - Secondary pixels become RGB 8.8.8, YCbCr converted when bit 0 of the format register is set.
// - Horizontal enlargement interpolates; vertical enlargement repeats lines.
// - Three-bit filter select picks pass, 0-2-4-2-0, bilinear or 1-2-2-2-1.
// - Mode 000 is reset default: secondary opaque over primary.
// - Mode 001 puts primary opaque over secondary.
// - Modes 010 and 011 blend inside the window, dissolve or fade.
// - Mode 101 shows secondary where primary matches the colour key.
// - Mode 110 shows primary where secondary matches the key.
// - Bit 31 of opaque control enables fetch gating for opaque modes.
// - With gating on, hidden background fetches stop, then resume.
// - Dissolve output is (Pp*Kp + Ps*(8-Kp))/8, Kp taken at vsync.
// - Fade output is (Pp*Kp + Ps*Ks)/8, Ks taken at vsync.
`timescale 1ns/1ps
`default_nettype none
module osc_top (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_vsync,
    input wire logic i_line_start,
    input wire osc_pkg::osc_pix_type i_sec_pix,
    output logic o_sec_ready,
    input wire osc_pkg::osc_pix_type i_pri_pix,
    input wire logic i_in_window,
    input wire logic i_key_match,
    input wire logic [9:0] i_fetch_qword,
    output logic o_fetch_en,
    output logic o_line_repeat,
    output osc_pkg::osc_pix_type o_pix
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [31:0] sec_ctrl;
        logic [31:0] hscale;
        logic [31:0] vfac1;
        logic [31:0] vfac2;
        logic [31:0] vacc_init;
        logic [31:0] blend;
        logic [31:0] opaque;
        logic [31:0] fmt;
        logic [2:0] kp;
        logic [2:0] ks;
        logic signed [12:0] hacc;
        logic signed [12:0] vacc;
        logic [10:0] line_cnt;
        logic [23:0] cur_pix;
        logic [23:0] prev_pix;
        logic have_pix;
        logic repeat_line;
        logic [31:0] rdata;
        osc_pkg::osc_pix_type out;
    } osc_state_type;

    osc_state_type state_reg;
    osc_state_type state_next;
    osc_pkg::osc_pix_type sec_rgb;
    osc_pkg::osc_pix_type sec_in;
    logic need_src;

    // ----------------------------------------
    // Colour conversion stage
    // ----------------------------------------
    assign sec_in.valid = i_sec_pix.valid & need_src;
    assign sec_in.data = i_sec_pix.data;
    assign o_sec_ready = need_src;

    osc_csc u_csc (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_yuv(state_reg.fmt[osc_pkg::YUV_BIT]),
        .i_pix(sec_in),
        .o_pix(sec_rgb)
    );

    function automatic logic [7:0] filt(input logic [2:0] sel, input logic [7:0] a,
                                        input logic [7:0] b, input logic frac);
        logic [9:0] s;
        s = 10'h000;
        case (sel)
            osc_pkg::FILT_PASS: s = {a, 2'b00};
            osc_pkg::FILT_LIN024: s = frac ? {1'b0, a, 1'b0} + {1'b0, b, 1'b0} : {a, 2'b00};
            osc_pkg::FILT_BILIN: s = frac ? ({2'b00, a} + {1'b0, b, 1'b0} + {2'b00, b}) : {a, 2'b00};
            osc_pkg::FILT_LIN122: s = {1'b0, a, 1'b0} + {1'b0, b, 1'b0};
            default: s = {a, 2'b00};
        endcase
        filt = s[9:2];
    endfunction

    function automatic logic [7:0] mix(input logic [7:0] p, input logic [7:0] s,
                                       input logic [3:0] wp, input logic [3:0] ws);
        logic [11:0] sum;
        // Operands are widened first so the product keeps its top bits.
        sum = 12'(p) * 12'(wp) + 12'(s) * 12'(ws);
        mix = sum[10:3];
    endfunction

    // Source advances when the DDA adds its first factor, or a pixel is still missing.
    assign need_src = !state_reg.have_pix || (state_reg.hacc >= 0);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [2:0] mode;
        logic [23:0] hpix;
        logic [3:0] wp;
        logic [3:0] ws;
        logic use_sec;
        logic signed [12:0] k1;
        logic signed [12:0] k2;
        mode = state_reg.blend[osc_pkg::MODE_LSB +: 3];
        k1 = 13'(signed'(state_reg.hscale[osc_pkg::K1_LSB +: 11]));
        k2 = 13'(signed'(state_reg.hscale[osc_pkg::K2_LSB +: 11]));
        hpix = 24'h000000;
        wp = 4'h0;
        ws = 4'h0;
        use_sec = 1'b0;
        state_next = state_reg;
        state_next.rdata = 32'h0000_0000;
        state_next.out.valid = 1'b0;

        if (i_wr) begin
            case (i_addr)
                osc_pkg::ADDR_SEC_CTRL: state_next.sec_ctrl = i_wdata;
                osc_pkg::ADDR_HSCALE: state_next.hscale = i_wdata;
                osc_pkg::ADDR_VFAC1: state_next.vfac1 = i_wdata;
                osc_pkg::ADDR_VFAC2: state_next.vfac2 = i_wdata;
                osc_pkg::ADDR_VACC: state_next.vacc_init = i_wdata;
                osc_pkg::ADDR_BLEND: state_next.blend = i_wdata;
                osc_pkg::ADDR_OPAQUE: state_next.opaque = i_wdata;
                osc_pkg::ADDR_FMT: state_next.fmt = i_wdata;
                default: state_next.sec_ctrl = state_reg.sec_ctrl;
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                osc_pkg::ADDR_SEC_CTRL: state_next.rdata = state_reg.sec_ctrl;
                osc_pkg::ADDR_HSCALE: state_next.rdata = state_reg.hscale;
                osc_pkg::ADDR_VFAC1: state_next.rdata = state_reg.vfac1;
                osc_pkg::ADDR_VFAC2: state_next.rdata = state_reg.vfac2;
                osc_pkg::ADDR_VACC: state_next.rdata = state_reg.vacc_init;
                osc_pkg::ADDR_BLEND: state_next.rdata = state_reg.blend;
                osc_pkg::ADDR_OPAQUE: state_next.rdata = state_reg.opaque;
                osc_pkg::ADDR_FMT: state_next.rdata = state_reg.fmt;
                osc_pkg::ADDR_STATUS: state_next.rdata = {18'h00000, state_reg.repeat_line,
                                                          state_reg.kp, state_reg.ks, state_reg.line_cnt[6:0]};
                default: state_next.rdata = 32'h0000_0000;
            endcase
        end

        // Weights change only at vsync so a frame never shows a mixed blend.
        if (i_vsync) begin
            state_next.kp = state_reg.blend[osc_pkg::KP_LSB +: 3];
            state_next.ks = state_reg.blend[osc_pkg::KS_LSB +: 3];
            state_next.vacc = 13'(signed'(state_reg.vacc_init[11:0]));
            state_next.line_cnt = 11'h000;
            state_next.repeat_line = 1'b0;
        end else if (i_line_start) begin
            // Vertical DDA: a negative accumulator repeats the previous source line.
            state_next.hacc = 13'(signed'(state_reg.sec_ctrl[osc_pkg::HACC_LSB +: 12]));
            state_next.have_pix = 1'b0;
            if (state_reg.vacc >= 0) begin
                state_next.vacc = state_reg.vacc + 13'(signed'(state_reg.vfac1[10:0]));
                state_next.repeat_line = 1'b0;
                state_next.line_cnt = state_reg.line_cnt + 11'h001;
            end else begin
                state_next.vacc = state_reg.vacc + 13'(signed'(state_reg.vfac2[10:0]));
                state_next.repeat_line = 1'b1;
            end
        end

        // Horizontal DDA steps once per output pixel, paced by the primary stream.
        if (sec_rgb.valid) begin
            state_next.prev_pix = state_reg.cur_pix;
            state_next.cur_pix = sec_rgb.data;
            state_next.have_pix = 1'b1;
        end
        if (i_pri_pix.valid && !i_line_start) begin
            if (state_reg.hacc >= 0) begin
                state_next.hacc = state_reg.hacc + k1;
            end else begin
                state_next.hacc = state_reg.hacc + k2;
            end
            for (int c = 0; c < 3; c++) begin
                hpix[c*8 +: 8] = filt(state_reg.sec_ctrl[osc_pkg::FILT_LSB +: 3],
                                      state_reg.cur_pix[c*8 +: 8], state_reg.prev_pix[c*8 +: 8],
                                      state_reg.hacc < 0);
            end
            state_next.out.valid = 1'b1;
            state_next.out.data = i_pri_pix.data;
            if (i_in_window) begin
                case (mode)
                    osc_pkg::MODE_SEC_OPAQUE: use_sec = 1'b1;
                    osc_pkg::MODE_PRI_OPAQUE: use_sec = 1'b0;
                    osc_pkg::MODE_SEC_KEY: use_sec = i_key_match;
                    osc_pkg::MODE_PRI_KEY: use_sec = !i_key_match;
                    default: use_sec = 1'b0;
                endcase
                if (mode == osc_pkg::MODE_DISSOLVE || mode == osc_pkg::MODE_FADE) begin
                    wp = {1'b0, state_reg.kp};
                    ws = (mode == osc_pkg::MODE_DISSOLVE) ? osc_pkg::BLEND_FULL - wp : {1'b0, state_reg.ks};
                    for (int c = 0; c < 3; c++) begin
                        state_next.out.data[c*8 +: 8] = mix(i_pri_pix.data[c*8 +: 8], hpix[c*8 +: 8], wp, ws);
                    end
                end else if (use_sec) begin
                    state_next.out.data = hpix;
                end
            end
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Fetch gating only uses the programmed quadword window; software keeps it to opaque modes.
    always_comb begin
        o_fetch_en = 1'b1;
        if (state_reg.opaque[osc_pkg::OPQ_EN_BIT] &&
            i_fetch_qword >= state_reg.opaque[osc_pkg::STOP_LSB +: 10] &&
            i_fetch_qword <= state_reg.opaque[osc_pkg::RESTART_LSB +: 10]) begin
            o_fetch_en = 1'b0;
        end
    end

    assign o_rdata = state_reg.rdata;
    assign o_line_repeat = state_reg.repeat_line;
    assign o_pix = state_reg.out;

endmodule
`default_nettype wire
